// ---- burst_port_pkg.sv ----
package burst_port_pkg;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] LAST_CMD_OFFSET = 8'h08;
  localparam logic [7:0] MEM_INDEX_OFFSET = 8'h0c;
  localparam logic [7:0] MEM_DATA_OFFSET = 8'h10;

  // ==========================================================
  // Control fields
  localparam int CTRL_LAT_LSB = 0;
  localparam int CTRL_LAT_W = 4;
  localparam int CTRL_EXTRA_BIT = 4;
  localparam int CTRL_WRAP_LSB = 5;
  localparam int CTRL_ERROR_BIT = 7;
  localparam int CTRL_PAUSE_BIT = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0006;

  // ==========================================================
  // Status fields
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_CFG_LSB = 16;

  // ==========================================================
  // Command word fields
  localparam int CMD_READ_BIT = 47;
  localparam int CMD_SPACE_BIT = 46;
  localparam int CMD_LINEAR_BIT = 45;
  localparam int CMD_BYTES = 6;

  // ==========================================================
  // Link constants
  localparam logic [15:0] LINK_CFG_RESET = 16'h0000;
  localparam logic [15:0] DEVICE_IDENT = 16'h5a5a; // Arbitrary value
  localparam logic [1:0] PAUSE_CLOCKS = 2'h2;
  localparam logic [5:0] PAUSE_BOUNDARY = 6'h00;
  localparam logic [31:0] WRAP_BASE_WORDS = 32'h0000_0008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Link states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_LAT = 5'h04,
    ST_READ = 5'h08,
    ST_WRITE = 5'h10
  } link_state_t;

endpackage : burst_port_pkg

// ---- link_sync.sv ----
`timescale 1ns/1ps
module link_sync #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin levels
  input wire logic [W-1:0] pins,
  output logic [W-1:0] synced
);

  // ==========================================================
  // Two stage synchroniser
  logic [W-1:0] stage1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '1;
      synced <= '1;
    end else begin
      stage1 <= pins;
      synced <= stage1;
    end
  end

endmodule : link_sync

// ---- word_store.sv ----
`timescale 1ns/1ps
module word_store (
  // Clock
  input wire logic aclk,
  // Software port
  input wire logic a_we,
  input wire logic [1:0] a_be,
  input wire logic [7:0] a_index,
  input wire logic [15:0] a_wdata,
  output logic [15:0] a_rdata,
  // Link port
  input wire logic b_we,
  input wire logic [1:0] b_be,
  input wire logic [7:0] b_index,
  input wire logic [15:0] b_wdata,
  output logic [15:0] b_rdata
);

  // ==========================================================
  // Word array, link write after software write
  logic [15:0] mem [0:255];

  always_ff @(posedge aclk) begin
    if (a_we && a_be[1]) begin
      mem[a_index][15:8] <= a_wdata[15:8];
    end
    if (a_we && a_be[0]) begin
      mem[a_index][7:0] <= a_wdata[7:0];
    end
    if (b_we && b_be[1]) begin
      mem[b_index][15:8] <= b_wdata[15:8];
    end
    if (b_we && b_be[0]) begin
      mem[b_index][7:0] <= b_wdata[7:0];
    end
    a_rdata <= mem[a_index];
    b_rdata <= mem[b_index];
  end

endmodule : word_store

// ---- burst_read_port.sv ----
`timescale 1ns/1ps
// What this block does
// - Register reads: upper byte first, strobe aligned
// - Register writes: upper on rise, lower on fall
// - Register space always big-endian, fixed bits
// - Strobe masks write bytes; masked bytes skipped
// - Zero-latency writes: full words, strobe held low
// - First word: read, space, burst type bits
// - Access may start after upper address bits
// - Latency once, doubled if strobe high
// - After latency, toggle strobe with each byte
// - Keep sending while clock toggles, selected
// - Strobe may pause low between words
// - Strobe low 32+ clocks signals error
// - Wrapped bursts wrap; linear advances sequentially
// - Data past last address is undefined
// - Clock may stop while deselected
module burst_read_port (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Register bus read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Link pins
  input wire logic link_ck,
  input wire logic clock_complement,
  input wire logic select_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic read_write_strobe_in,
  output logic read_write_strobe_out,
  output logic read_write_strobe_oe
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) merge[8*i +: 8] = nw[8*i +: 8];
    end
  endfunction : merge

  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic lin,
                                            input logic [1:0] sel);
    logic [31:0] m;
    m = (burst_port_pkg::WRAP_BASE_WORDS << sel) - 32'h0000_0001;
    step_addr = lin ? a + 32'h0000_0001 : (a & ~m) | ((a + 32'h0000_0001) & m);
  endfunction : step_addr

  // ==========================================================
  // Pin synchronisers and clock edges
  logic [11:0] synced;
  logic s_ck, s_ckn, s_cs_n, s_read_write_strobe, ck_q;
  logic [7:0] s_dq;

  link_sync #(.W(12)) link_sync_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins({link_ck, clock_complement, select_n, read_write_strobe_in, dq_in}),
    .synced(synced)
  );

  assign {s_ck, s_ckn, s_cs_n, s_read_write_strobe, s_dq} = synced;

  always_ff @(posedge aclk) begin
    if (!aresetn) ck_q <= 1'b0;
    else ck_q <= s_ck;
  end

  wire ck_rise = s_ck & ~ck_q;
  wire ck_fall = ~s_ck & ck_q;
  wire ck_edge = ck_rise | ck_fall;

  // ==========================================================
  // Registers
  logic [31:0] ctrl, mem_index, last_cmd;
  logic [15:0] link_cfg, mem_a_q, mem_b_q;
  burst_port_pkg::link_state_t state;

  wire [3:0] lat_set = ctrl[burst_port_pkg::CTRL_LAT_LSB +: burst_port_pkg::CTRL_LAT_W];
  wire extra = ctrl[burst_port_pkg::CTRL_EXTRA_BIT];
  wire [1:0] wrap_sel = ctrl[burst_port_pkg::CTRL_WRAP_LSB +: 2];
  wire [2:0] wrap_log = {1'b0, wrap_sel} + 3'h3;
  wire err_hold = ctrl[burst_port_pkg::CTRL_ERROR_BIT];
  wire pause_en = ctrl[burst_port_pkg::CTRL_PAUSE_BIT];

  // ==========================================================
  // Register bus slave
  logic aw_held, w_held, ar_held;
  logic [7:0] aw_addr_q, ar_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  assign awready = ~aw_held & ~bvalid;
  assign wready = ~w_held & ~bvalid;
  assign arready = ~ar_held & ~rvalid;

  wire do_write = aw_held & w_held;
  wire wr_ctrl = do_write && aw_addr_q == burst_port_pkg::CTRL_OFFSET;
  wire wr_index = do_write && aw_addr_q == burst_port_pkg::MEM_INDEX_OFFSET;
  wire wr_mem = do_write && aw_addr_q == burst_port_pkg::MEM_DATA_OFFSET;
  wire wr_known = wr_ctrl | wr_index | wr_mem |
                  aw_addr_q == burst_port_pkg::STATUS_OFFSET |
                  aw_addr_q == burst_port_pkg::LAST_CMD_OFFSET;

  wire [31:0] status_word = {link_cfg, 11'h000, state};
  wire rd_known = ar_addr_q == burst_port_pkg::CTRL_OFFSET ||
                  ar_addr_q == burst_port_pkg::STATUS_OFFSET ||
                  ar_addr_q == burst_port_pkg::LAST_CMD_OFFSET ||
                  ar_addr_q == burst_port_pkg::MEM_INDEX_OFFSET ||
                  ar_addr_q == burst_port_pkg::MEM_DATA_OFFSET;
  wire [31:0] rd_mux =
    ar_addr_q == burst_port_pkg::CTRL_OFFSET ? ctrl :
    ar_addr_q == burst_port_pkg::STATUS_OFFSET ? status_word :
    ar_addr_q == burst_port_pkg::LAST_CMD_OFFSET ? last_cmd :
    ar_addr_q == burst_port_pkg::MEM_INDEX_OFFSET ? mem_index :
    ar_addr_q == burst_port_pkg::MEM_DATA_OFFSET ? {16'h0000, mem_a_q} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      bvalid <= 1'b0;
      bresp <= burst_port_pkg::RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_known ? burst_port_pkg::RESP_OKAY : burst_port_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_held <= 1'b0;
      ar_addr_q <= 8'h00;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= burst_port_pkg::RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        ar_held <= 1'b1;
        ar_addr_q <= araddr;
      end else if (ar_held) begin
        ar_held <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_known ? burst_port_pkg::RESP_OKAY : burst_port_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= burst_port_pkg::CTRL_RESET;
      mem_index <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) ctrl <= merge(ctrl, w_data_q, w_strb_q);
      if (wr_index) mem_index <= merge(mem_index, w_data_q, w_strb_q);
    end
  end

  // ==========================================================
  // Link transaction engine
  logic [47:0] ca;
  logic [2:0] ca_cnt;
  logic [4:0] lat_cnt;
  logic [31:0] addr;
  logic [1:0] pause_cnt;
  logic lo_pending, use_mask, mask_hi, link_we;
  logic [7:0] wr_hi, wr_pos;
  logic [15:0] wr_word;
  logic [1:0] wr_be;

  wire [47:0] next_ca = {ca[39:0], s_dq};
  wire cmd_read = next_ca[burst_port_pkg::CMD_READ_BIT];
  wire cmd_reg = next_ca[burst_port_pkg::CMD_SPACE_BIT];
  wire [4:0] lat_total = extra ? {lat_set, 1'b0} : {1'b0, lat_set};
  wire go_data = (~cmd_read & cmd_reg) | (lat_total == 5'h00);
  wire is_read = ca[burst_port_pkg::CMD_READ_BIT];
  wire is_reg = ca[burst_port_pkg::CMD_SPACE_BIT];
  wire is_linear = ca[burst_port_pkg::CMD_LINEAR_BIT];
  wire [31:0] stepped = step_addr(addr, is_linear, wrap_sel);
  wire [15:0] reg_word = addr[0] ? burst_port_pkg::DEVICE_IDENT : link_cfg;
  wire [15:0] rd_word = is_reg ? reg_word : mem_b_q;
  wire [7:0] link_index = link_we ? wr_pos : addr[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= burst_port_pkg::ST_IDLE;
      {ca_cnt, lat_cnt, pause_cnt, lo_pending, link_we} <= '0;
      {dq_oe, read_write_strobe_oe, read_write_strobe_out} <= '0;
      {ca, addr, dq_out, use_mask, mask_hi, wr_hi, wr_pos, wr_word, wr_be} <= '0;
    end else if (s_cs_n) begin
      state <= burst_port_pkg::ST_IDLE;
      {ca_cnt, lat_cnt, pause_cnt, lo_pending, link_we} <= '0;
      {dq_oe, read_write_strobe_oe, read_write_strobe_out} <= '0;
    end else begin
      link_we <= 1'b0;
      case (state)
        burst_port_pkg::ST_IDLE: begin
          if (!s_ck && s_ckn) begin
            state <= burst_port_pkg::ST_CMD;
            read_write_strobe_oe <= 1'b1;
            read_write_strobe_out <= extra;
          end
        end
        burst_port_pkg::ST_CMD: begin
          if (ck_edge) begin
            ca <= next_ca;
            ca_cnt <= ca_cnt + 3'h1;
            if (ca_cnt == 3'(burst_port_pkg::CMD_BYTES - 1)) begin
              addr <= {next_ca[44:16], next_ca[2:0]};
              state <= go_data ? (cmd_read ? burst_port_pkg::ST_READ : burst_port_pkg::ST_WRITE)
                               : burst_port_pkg::ST_LAT;
              use_mask <= ~go_data;
              read_write_strobe_oe <= cmd_read | go_data;
              read_write_strobe_out <= 1'b0;
            end
          end
        end
        burst_port_pkg::ST_LAT: begin
          if (ck_rise) begin
            lat_cnt <= lat_cnt + 5'h01;
            if (lat_cnt + 5'h01 == lat_total) begin
              state <= is_read ? burst_port_pkg::ST_READ : burst_port_pkg::ST_WRITE;
            end
          end
        end
        burst_port_pkg::ST_READ: begin
          if (ck_rise && !err_hold) begin
            if (pause_cnt != 2'h0) begin
              pause_cnt <= pause_cnt - 2'h1;
            end else begin
              dq_out <= rd_word[15:8];
              dq_oe <= 1'b1;
              read_write_strobe_out <= 1'b1;
              lo_pending <= 1'b1;
            end
          end else if (ck_fall && lo_pending) begin
            dq_out <= rd_word[7:0];
            read_write_strobe_out <= 1'b0;
            lo_pending <= 1'b0;
            addr <= stepped;
            if (pause_en && stepped[5:0] == burst_port_pkg::PAUSE_BOUNDARY) begin
              pause_cnt <= burst_port_pkg::PAUSE_CLOCKS;
            end
          end
        end
        burst_port_pkg::ST_WRITE: begin
          if (ck_rise) begin
            wr_hi <= s_dq;
            mask_hi <= use_mask & s_read_write_strobe;
            lo_pending <= 1'b1;
          end else if (ck_fall && lo_pending) begin
            link_we <= 1'b1;
            wr_word <= {wr_hi, s_dq};
            wr_be <= ~{mask_hi, use_mask & s_read_write_strobe};
            wr_pos <= addr[7:0];
            addr <= stepped;
            lo_pending <= 1'b0;
          end
        end
        default: state <= burst_port_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Device configuration word and command record
  wire [31:0] cfg_merged = merge({16'h0000, link_cfg}, {16'h0000, wr_word}, {2'b00, wr_be});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_cfg <= burst_port_pkg::LINK_CFG_RESET;
      last_cmd <= 32'h0000_0000;
    end else begin
      if (link_we && is_reg) link_cfg <= cfg_merged[15:0];
      if (state == burst_port_pkg::ST_CMD && ck_edge &&
          ca_cnt == 3'(burst_port_pkg::CMD_BYTES - 1)) last_cmd <= next_ca[47:16];
    end
  end

  word_store word_store_i (
    .aclk(aclk),
    .a_we(wr_mem),
    .a_be(w_strb_q[1:0]),
    .a_index(mem_index[7:0]),
    .a_wdata(w_data_q[15:0]),
    .a_rdata(mem_a_q),
    .b_we(link_we & ~is_reg),
    .b_be(wr_be),
    .b_index(link_index),
    .b_wdata(wr_word),
    .b_rdata(mem_b_q)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_release_pins: assert property (s_cs_n |=> !dq_oe && !read_write_strobe_oe)
    else $error("pins not released after deselect");
  a_upper_byte: assert property (state == burst_port_pkg::ST_READ && ck_rise && !err_hold &&
    pause_cnt == 2'h0 && !s_cs_n |=> dq_out == $past(rd_word[15:8]) && read_write_strobe_out)
    else $error("upper byte not driven with strobe high");
  a_lower_byte: assert property (state == burst_port_pkg::ST_READ && ck_fall && lo_pending &&
    !s_cs_n |=> dq_out == $past(rd_word[7:0]) && !read_write_strobe_out)
    else $error("lower byte not driven with strobe low");
  a_cmd_strobe: assert property (state == burst_port_pkg::ST_CMD |->
    read_write_strobe_oe && read_write_strobe_out == extra)
    else $error("strobe does not show latency flag");
  a_latency_end: assert property (state == burst_port_pkg::ST_LAT && ck_rise && !s_cs_n &&
    lat_cnt + 5'h01 == lat_total |=> state != burst_port_pkg::ST_LAT)
    else $error("latency count overrun");
  a_read_path: assert property (state == burst_port_pkg::ST_READ |-> is_read)
    else $error("read path without read command");
  a_error_low: assert property (state == burst_port_pkg::ST_READ && err_hold &&
    !read_write_strobe_out |=> !read_write_strobe_out)
    else $error("strobe toggled during error hold");
  a_wrap_bound: assert property (state == burst_port_pkg::ST_READ && ck_fall && lo_pending &&
    !is_linear && !s_cs_n && $stable(wrap_sel) |=>
    (addr >> wrap_log) == ($past(addr) >> wrap_log))
    else $error("wrapped burst left its window");
  a_zero_write: assert property (state == burst_port_pkg::ST_WRITE && !use_mask |->
    read_write_strobe_oe && !read_write_strobe_out)
    else $error("zero latency write strobe not low");

  c_mem_read: cover property (state == burst_port_pkg::ST_READ && !is_reg && ck_fall && lo_pending);
  c_reg_read: cover property (state == burst_port_pkg::ST_READ && is_reg && ck_fall && lo_pending);
  c_masked_write: cover property (link_we && wr_be != 2'h3);
  c_pause: cover property (pause_cnt == burst_port_pkg::PAUSE_CLOCKS);

endmodule : burst_read_port

// ---- link_master.sv ----
`timescale 1ns/1ps
module link_master (
  // Link pins
  output logic link_ck,
  output logic clock_complement,
  output logic select_n,
  output logic [7:0] dq_in,
  output logic read_write_strobe_in,
  // Device drive
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire logic read_write_strobe_out,
  input wire logic read_write_strobe_oe
);
  logic [7:0] m_dq = 8'h00;
  logic m_oe = 1'b0;
  logic m_s = 1'b0;
  logic m_soe = 1'b0;
  logic [15:0] words[$];
  logic [15:0] wd[$];
  logic [1:0] wm[$];
  logic ca_s;
  logic s_bad;
  int first;
  int clks;
  // ==========================================================
  // Released lines show a toggling pattern
  assign dq_in = m_oe ? m_dq : (dq_oe ? dq_out : {4{link_ck, ~link_ck}});
  assign read_write_strobe_in = m_soe ? m_s :
    (read_write_strobe_oe ? read_write_strobe_out : ~link_ck);
  initial begin
    link_ck = 1'b0;
    clock_complement = 1'b1;
    select_n = 1'b1;
  end
  task automatic tick();
    #20;
    link_ck = ~link_ck;
    clock_complement = ~link_ck;
    #20;
  endtask : tick
  // Select with clock idle, then command bytes
  task automatic run(input logic [47:0] cmd, input int lat, input int n);
    int lowc;
    logic [7:0] up;
    words = {};
    first = 0;
    clks = 0;
    lowc = 0;
    s_bad = 1'b0;
    // Step off the sampling edge of the block clock
    #2;
    select_n = 1'b0;
    m_oe = 1'b1;
    #40;
    for (int i = 5; i >= 0; i--) begin
      m_dq = cmd[i*8 +: 8];
      tick();
      if (i == 4) ca_s = read_write_strobe_out;
    end
    if (!cmd[47]) begin
      repeat (2 * lat) tick();
      // Upper on rise, mask only with latency
      m_soe = (lat > 0);
      for (int k = 0; k < wd.size(); k++) begin
        m_dq = wd[k][15:8];
        m_s = wm[k][1];
        tick();
        if (read_write_strobe_oe === 1'b1 && read_write_strobe_out !== 1'b0) s_bad = 1'b1;
        m_dq = wd[k][7:0];
        m_s = wm[k][0];
        tick();
      end
    end else begin
      m_oe = 1'b0;
      // Capture on strobe changes, quit after 32 low clocks
      while (words.size() < n && lowc < 32) begin
        tick();
        clks++;
        if (read_write_strobe_out === 1'b1) begin
          up = dq_out;
          if (first == 0) first = clks;
          tick();
          if (read_write_strobe_out === 1'b0) words.push_back({up, dq_out});
          lowc = 0;
        end else begin
          tick();
          lowc++;
        end
      end
    end
    // Deselect with clock idle, clock stops
    m_oe = 1'b0;
    m_soe = 1'b0;
    #20;
    select_n = 1'b1;
    #80;
  endtask : run
endmodule : link_master

// ---- burst_read_port_tb.sv ----
`timescale 1ns/1ps
module burst_read_port_tb;
  // ==========================================================
  // Signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dq_oe, s_in, s_out, s_oe;
  logic link_ck, ck_n, sel_n;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd, cv, v;
  logic [7:0] dq_in, dq_out, a;
  logic [15:0] mem [256];
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int le;
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      stop_test();
    end
  end
  burst_read_port burst_read_port_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link_ck(link_ck), .clock_complement(ck_n), .select_n(sel_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .read_write_strobe_in(s_in),
    .read_write_strobe_out(s_out), .read_write_strobe_oe(s_oe));
  link_master link_master_i (.link_ck(link_ck), .clock_complement(ck_n), .select_n(sel_n),
    .dq_in(dq_in), .read_write_strobe_in(s_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .read_write_strobe_out(s_out), .read_write_strobe_oe(s_oe));
  // ==========================================================
  // Helpers
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
    logic ad_d, w_d, b_d;
    ad_d = 0;
    w_d = 0;
    b_d = 0;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad_d && w_d && b_d)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad_d = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_d = 1;
        wvalid <= 1'b0;
      end
      if (bvalid && bready) begin
        b_d = 1;
        rsp = bresp;
        bready <= 1'b0;
      end
    end
  endtask : axw
  task automatic axr(input logic [7:0] ad);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axr
  function automatic logic [47:0] mk(logic r, logic sp, logic lin, logic [7:0] ad);
    mk = {r, sp, lin, 24'h0, ad[7:3], 13'h0, ad[2:0]};
  endfunction : mk
  function automatic logic [7:0] nxt(logic [7:0] ad, logic lin, logic [1:0] ws);
    logic [7:0] m;
    m = (8'h08 << ws) - 8'h01;
    nxt = lin ? ad + 8'h01 : (ad & ~m) | ((ad + 8'h01) & m);
  endfunction : nxt
  task automatic cfg(input logic [31:0] c);
    cv = c;
    axw(burst_port_pkg::CTRL_OFFSET, c, 4'hf);
    check("bresp", rsp, burst_port_pkg::RESP_OKAY);
    le = c[4] ? 2 * c[3:0] : c[3:0];
  endtask : cfg
  task automatic link(input logic [47:0] cmd, input int lat, input int n);
    link_master_i.run(cmd, lat, n);
    repeat (6) @(posedge aclk);
    check("dq_oe", dq_oe, 1'b0);
    check("strobe_oe", s_oe, 1'b0);
    axr(burst_port_pkg::STATUS_OFFSET);
    check("state", rd[4:0], 5'h01);
  endtask : link
  task automatic rd_check(input logic lin, input logic [7:0] a0, input int n);
    logic [7:0] x;
    x = a0;
    link(mk(1'b1, 1'b0, lin, a0), le, n);
    check("ca strobe", link_master_i.ca_s, cv[4]);
    check("first", link_master_i.first, le + 1);
    check("count", link_master_i.words.size(), n);
    for (int k = 0; k < link_master_i.words.size(); k++) begin
      check("word", link_master_i.words[k], mem[x]);
      x = nxt(x, lin, cv[6:5]);
    end
  endtask : rd_check
  // ==========================================================
  // Main sequence
  initial begin
    v = $urandom(32'h0e2ee9ec);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axr(burst_port_pkg::CTRL_OFFSET);
    check("ctrl reset", rd, burst_port_pkg::CTRL_RESET);
    axr(8'h20);
    check("unmapped", rsp, burst_port_pkg::RESP_SLVERR);
    axw(8'h20, 32'h0000_0000, 4'hf);
    check("unmapped wr", rsp, burst_port_pkg::RESP_SLVERR);
    for (int i = 0; i < 256; i++) begin
      mem[i] = $urandom;
      axw(burst_port_pkg::MEM_INDEX_OFFSET, i, 4'hf);
      axw(burst_port_pkg::MEM_DATA_OFFSET, {16'h0, mem[i]}, 4'h3);
    end
    cfg(32'h0000_0000);
    rd_check(1'b0, 8'h07, 10);
    for (int t = 0; t < 6; t++) begin
      v = $urandom;
      cfg(v & 32'h0000_0073);
      rd_check(v[7], v[15:8], 12);
    end
    cfg(32'h0000_0102);
    rd_check(1'b1, 8'h3e, 4);
    check("pause clocks", link_master_i.clks, le + 1 + 3 + 2);
    cfg(32'h0000_0082);
    link(mk(1'b1, 1'b0, 1'b1, 8'h00), le, 4);
    check("error words", link_master_i.words.size(), 0);
    check("error clocks", link_master_i.clks, 32);
    cfg(32'h0000_0002);
    link(mk(1'b1, 1'b1, 1'b1, 8'h01), le, 1);
    check("ident", link_master_i.words[0], burst_port_pkg::DEVICE_IDENT);
    link_master_i.wd = {16'hc3a5};
    link_master_i.wm = {2'b11};
    link(mk(1'b0, 1'b1, 1'b0, 8'h00), 0, 0);
    check("strobe low", link_master_i.s_bad, 1'b0);
    check("cfg status", rd[31:16], 16'hc3a5);
    link(mk(1'b1, 1'b1, 1'b1, 8'h00), le, 1);
    check("cfg word", link_master_i.words[0], 16'hc3a5);
    axr(burst_port_pkg::LAST_CMD_OFFSET);
    check("last cmd", rd, mk(1'b1, 1'b1, 1'b1, 8'h00) >> 16);
    cfg(32'h0000_0013);
    a = $urandom;
    link_master_i.wd = {$urandom, $urandom, $urandom};
    link_master_i.wm = {2'b10, 2'b00, 2'b01};
    link(mk(1'b0, 1'b0, 1'b1, a), le, 0);
    for (int k = 0; k < 3; k++) begin
      v = {link_master_i.wd[k], 14'h0, link_master_i.wm[k]};
      mem[a] = {v[1] ? mem[a][15:8] : v[31:24], v[0] ? mem[a][7:0] : v[23:16]};
      axw(burst_port_pkg::MEM_INDEX_OFFSET, {24'h0, a}, 4'hf);
      axr(burst_port_pkg::MEM_DATA_OFFSET);
      check("masked", rd[15:0], mem[a]);
      a = a + 8'h01;
    end
    stop_test();
  end
endmodule : burst_read_port_tb
